// ===== fifo_mem.sv
// Purpose: 64-byte FIFO storage
// Assumes: Pointers kept by the owner
// Notes:   Read data one cycle after address
`timescale 1ns/100ps
`include "modem_defs.svh"
module fifo_mem (
  input wire logic clock,
  fifo_mem_if.mem  m
);
  logic [7:0] ram [0:(1<<`AW)-1];

  always_ff @(posedge clock) begin
    if (m.we) begin
      ram[m.waddr] <= m.wdata;
    end
  end

  always_ff @(posedge clock) begin
    m.rdata <= ram[m.raddr];
  end
endmodule // fifo_mem

// ===== fifo_mem_if.sv
// Purpose: Carrier between FIFO control and its memory
// Assumes: Single clock, write and read in the same cycle allowed
// Notes:   Read data are registered in the memory
`timescale 1ns/100ps
`include "modem_defs.svh"
interface fifo_mem_if;
  logic             we;
  logic [`AW-1:0]   waddr;
  logic [`AW-1:0]   raddr;
  logic [7:0]       wdata;
  logic [7:0]       rdata;
  modport ctrl (output we, waddr, raddr, wdata, input rdata);
  modport mem  (input we, waddr, raddr, wdata, output rdata);
endinterface

// ===== modem_data_path.sv
// Purpose: Modulation config, FIFO command link, direct mode, demod
// Assumes: Host leaves >= 8 core clocks between link bytes
// Notes:   Answers on the serial output lag their cause by two bytes
`timescale 1ns/100ps
`include "modem_defs.svh"
// What this block does
// - One 8-bit config register holds modulation
// - Low three bits pick the modulation scheme
// - Bits 4:3 pick FIFO, pin or PRBS
// - Bits 6:5 pick the direct transmit pin
// - Bit 7 async timing; Gaussian forces sync
// - Sync demod needs alternating preamble, low index
// - Bit clock locks after four transitions
// - Async demod deglitches and gives sample clock
// - Async demod locks on any preamble
// - Command 66h then bytes fills TX FIFO
// - Command 77h then clocks drains RX FIFO
// - Packet handler on: add preamble and sync
// - Packet handler off: send FIFO bytes only
// - Packet handler on: store only payload bytes
// - Packet handler off: store all after sync
// - Received bits shown live on a pin
// - Packet done leaves to commanded next state
// - Direct transmit modulates pin data live
// - Direct receive drives data and clock pins
// - Alert output low until status read
module modem_data_path (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       sclk,
  input  wire logic       nsel,
  input  wire logic       sdi,
  input  wire logic [3:0] gpio_i,
  input  wire logic       rx_raw,
  output logic            sdo_o,
  output logic            sdo_oe,
  output logic [3:0]      gpio_o,
  output logic [3:0]      gpio_oe,
  output logic            mod_bit,
  output logic [2:0]      mod_scheme,
  output logic            mod_active,
  output logic            host_alert_n
);
  // Link clock domain; stops between frames, so frame end clears count
  logic [2:0] sp_cnt;
  logic [7:0] sp_sh;
  logic [7:0] sp_byte;
  logic [7:0] sp_out;
  logic       sp_tgl = 1'b0;
  logic [7:0] out_byte_q;

  always_ff @(posedge sclk or posedge nsel) begin
    if (nsel) begin
      sp_cnt <= 3'h0;
    end else begin
      sp_cnt <= sp_cnt + 3'h1;
    end
  end

  always_ff @(posedge sclk) begin
    sp_sh <= {sp_sh[6:0], sdi};
    if (sp_cnt == 3'h7) begin
      sp_byte <= {sp_sh[6:0], sdi};
      sp_tgl  <= ~sp_tgl;
    end
  end

  // out_byte_q is held steady for bytes around this load
  always_ff @(negedge sclk) begin
    if (sp_cnt == 3'h0) begin
      sp_out <= out_byte_q;
      sdo_o  <= out_byte_q[7];
    end else begin
      sdo_o  <= sp_out[3'h7 - sp_cnt];
    end
  end

  // Core side synchronisers
  logic [2:0] tgl_s;
  logic [1:0] nsel_s;
  logic [3:0] gp_s1, gp_s2;
  always_ff @(posedge clock) begin
    if (rst) begin
      tgl_s  <= 3'h0;
      nsel_s <= 2'h3;
      gp_s1  <= 4'h0;
      gp_s2  <= 4'h0;
    end else begin
      tgl_s  <= {tgl_s[1:0], sp_tgl};
      nsel_s <= {nsel_s[0], nsel};
      gp_s1  <= gpio_i;
      gp_s2  <= gp_s1;
    end
  end
  wire       byte_ev  = tgl_s[2] ^ tgl_s[1];
  wire       frame_on = ~nsel_s[1];
  wire [7:0] rb       = sp_byte;

  // Command parser
  logic [7:0]  cmd_q;
  logic [2:0]  bidx_q;
  logic [15:0] addr_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_q  <= 8'h00;
      bidx_q <= 3'h0;
      addr_q <= 16'h0000;
    end else if (!frame_on) begin
      bidx_q <= 3'h0;
    end else if (byte_ev) begin
      if (bidx_q != `BIDX_MAX) bidx_q <= bidx_q + 3'h1;
      if (bidx_q == 3'h0) cmd_q <= rb;
      if (bidx_q == 3'h1) addr_q[15:8] <= rb;
      if (bidx_q == 3'h2) addr_q[7:0] <= rb;
    end
  end
  wire ev_cmd  = byte_ev & (bidx_q == 3'h0);
  wire ev_arg1 = byte_ev & (bidx_q == 3'h1);
  wire ev_data = byte_ev & (bidx_q != 3'h0);

  // Registers
  logic [7:0] cfg_q;
  logic [7:0] ctl_q;
  wire set_ev = byte_ev & (bidx_q == 3'h3) & (cmd_q == `CMD_SETP);
  wire rsv_wr = (rb[`F_SCHEME] > `SCH_MAX) | (rb[`F_SOURCE] == `SRC_RSV);
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_q <= `CFG_RST;
      ctl_q <= `CTL_RST;
    end else if (set_ev) begin
      if (addr_q == `CFG_ADDR && !rsv_wr) cfg_q <= rb;
      if (addr_q == `CTL_ADDR) ctl_q <= rb;
    end
  end
  wire [1:0] src   = cfg_q[`F_SOURCE];
  wire [1:0] dpin  = cfg_q[`F_PIN];
  wire       gauss = (cfg_q[`F_SCHEME] == `SCH_2GFSK) |
                     (cfg_q[`F_SCHEME] == `SCH_4GFSK);
  wire       dsync = ~cfg_q[`F_TIMING] | gauss;
  wire       ph_en = ctl_q[`C_PH_EN];
  wire       async = ctl_q[`C_ASYNC];

  // FIFOs
  fifo_mem_if txm ();
  fifo_mem_if rxm ();
  fifo_mem u_txmem (.clock(clock), .m(txm.mem));
  fifo_mem u_rxmem (.clock(clock), .m(rxm.mem));
  logic [`AW:0] tx_wp, tx_rp, rx_wp, rx_rp;
  wire [`AW:0] tx_cnt = tx_wp - tx_rp;
  wire [`AW:0] rx_cnt = rx_wp - rx_rp;
  wire tx_full  = tx_cnt[`AW];
  wire rx_full  = rx_cnt[`AW];
  wire tx_empty = (tx_cnt == '0);
  wire rx_empty = (rx_cnt == '0);
  wire rx_look  = (cmd_q == `CMD_RRX) & (bidx_q >= 3'h2);
  wire push_tx  = ev_data & (cmd_q == `CMD_WTX) & !tx_full;
  wire pop_rx   = byte_ev & rx_look & !rx_empty;
  logic       pop_tx, push_rx;
  logic [7:0] rx_byte;
  assign txm.we    = push_tx;
  assign txm.waddr = tx_wp[`AW-1:0];
  assign txm.wdata = rb;
  assign txm.raddr = tx_rp[`AW-1:0];
  assign rxm.we    = push_rx;
  assign rxm.waddr = rx_wp[`AW-1:0];
  assign rxm.wdata = rx_byte;
  // Look one ahead: the next byte must be ready before its slot starts
  assign rxm.raddr = rx_rp[`AW-1:0] + {{(`AW-1){1'b0}}, rx_look};

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_wp <= '0;
      tx_rp <= '0;
      rx_wp <= '0;
      rx_rp <= '0;
    end else begin
      if (push_tx) tx_wp <= tx_wp + 1'b1;
      if (pop_tx)  tx_rp <= tx_rp + 1'b1;
      if (push_rx) rx_wp <= rx_wp + 1'b1;
      if (pop_rx)  rx_rp <= rx_rp + 1'b1;
    end
  end

  // Radio state
  modem_pkg::radio_state_e state_q;
  logic [3:0] tx_next_q, rx_next_q;
  logic       tx_done_ev, rx_done_ev;
  function automatic modem_pkg::radio_state_e ns(input logic [3:0] c);
    if (c == `NS_TX) return modem_pkg::ST_TX;
    if (c == `NS_RX) return modem_pkg::ST_RX;
    return modem_pkg::ST_IDLE;
  endfunction
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q   <= modem_pkg::ST_IDLE;
      tx_next_q <= 4'h0;
      rx_next_q <= 4'h0;
    end else begin
      case (state_q)
        modem_pkg::ST_TX: if (tx_done_ev) state_q <= ns(tx_next_q);
        modem_pkg::ST_RX: if (rx_done_ev) state_q <= ns(rx_next_q);
        modem_pkg::ST_IDLE: state_q <= modem_pkg::ST_IDLE;
        default: state_q <= modem_pkg::ST_IDLE;
      endcase
      if (ev_arg1 && cmd_q == `CMD_TX) begin
        tx_next_q <= rb[3:0];
        state_q   <= modem_pkg::ST_TX;
      end
      if (ev_arg1 && cmd_q == `CMD_RX) begin
        rx_next_q <= rb[3:0];
        state_q   <= modem_pkg::ST_RX;
      end
      if (ev_arg1 && cmd_q == `CMD_CHG) state_q <= ns(rb[3:0]);
    end
  end
  wire in_tx = (state_q == modem_pkg::ST_TX);
  wire in_rx = (state_q == modem_pkg::ST_RX);

  // Transmit bit timing and byte builder
  logic [5:0] tb_q;
  logic [7:0] tx_sh;
  logic [2:0] tx_bn, seg_q;
  logic       tx_have;
  logic [8:0] prbs_q;
  wire tb_stb = (tb_q == 6'(`BIT_CYC - 1));
  wire fetch  = tb_stb & (!tx_have | (tx_bn == 3'h7));
  logic [7:0] fb;
  logic       fv;
  wire [15:0] sync_w = `SYNC_WORD;
  always_comb begin
    fb     = 8'h00;
    fv     = 1'b0;
    pop_tx = 1'b0;
    if (ph_en && seg_q < `PRE_BYTES) begin
      fb = `PRE_PAT;
      fv = 1'b1;
    end else if (ph_en && seg_q < `SEG_PAY) begin
      fb = (seg_q == `PRE_BYTES) ? sync_w[15:8] : sync_w[7:0];
      fv = 1'b1;
    end else if (!tx_empty) begin
      fb     = txm.rdata;
      fv     = 1'b1;
      pop_tx = fetch & in_tx & (src == `SRC_FIFO);
    end
  end
  assign tx_done_ev = in_tx & (src == `SRC_FIFO) & fetch & !fv;

  always_ff @(posedge clock) begin
    if (rst || !in_tx || tx_done_ev) begin
      tb_q    <= 6'h00;
      tx_bn   <= 3'h0;
      seg_q   <= 3'h0;
      tx_have <= 1'b0;
      tx_sh   <= 8'h00;
    end else begin
      tb_q <= tb_stb ? 6'h00 : tb_q + 6'h01;
      if (fetch) begin
        tx_sh   <= fb;
        tx_bn   <= 3'h0;
        tx_have <= 1'b1;
        if (seg_q != `SEG_PAY) seg_q <= seg_q + 3'h1;
      end else if (tb_stb) begin
        tx_sh <= {tx_sh[6:0], 1'b0};
        tx_bn <= tx_bn + 3'h1;
      end
    end
  end

  wire pin_d = gp_s2[dpin];
  always_ff @(posedge clock) begin
    if (rst) begin
      mod_bit <= 1'b0;
      prbs_q  <= `PRBS_SEED;
    end else if (in_tx) begin
      case (src)
        `SRC_PIN: begin
          if (!dsync || tb_stb) mod_bit <= pin_d;
        end
        `SRC_PRBS: begin
          if (tb_stb) begin
            prbs_q  <= {prbs_q[7:0], prbs_q[8] ^ prbs_q[4]};
            mod_bit <= prbs_q[8];
          end
        end
        default: begin
          if (fetch && fv) mod_bit <= fb[7];
          else if (tb_stb && tx_have) mod_bit <= tx_sh[6];
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mod_scheme <= 3'(`CFG_RST);
      mod_active <= 1'b0;
    end else begin
      mod_scheme <= cfg_q[`F_SCHEME];
      mod_active <= in_tx;
    end
  end

  // Demodulator bit recovery
  logic [2:0] dg_sh;
  logic       dbit_q, dprev_q;
  logic [5:0] rb_q;
  logic [2:0] edges_q;
  wire maj   = (dg_sh[0] & dg_sh[1]) | (dg_sh[1] & dg_sh[2]) |
               (dg_sh[0] & dg_sh[2]);
  wire edge_d = dbit_q ^ dprev_q;
  wire rx_stb = (rb_q == 6'(`BIT_CYC / 2));
  wire locked = async | (edges_q == `LOCK_EDGES);
  wire bit_ok = rx_stb & locked & in_rx;
  always_ff @(posedge clock) begin
    if (rst) begin
      dg_sh   <= 3'h0;
      dbit_q  <= 1'b0;
      dprev_q <= 1'b0;
      rb_q    <= 6'h00;
      edges_q <= 3'h0;
    end else begin
      dg_sh   <= {dg_sh[1:0], rx_raw};
      dbit_q  <= async ? maj : rx_raw;
      dprev_q <= dbit_q;
      if (edge_d || rb_q == 6'(`BIT_CYC - 1)) rb_q <= 6'h00;
      else rb_q <= rb_q + 6'h01;
      // Only alternating data gives edges every bit
      if (!in_rx) edges_q <= 3'h0;
      else if (edge_d && edges_q != `LOCK_EDGES)
        edges_q <= edges_q + 3'h1;
    end
  end

  // Receive framing
  modem_pkg::rx_phase_e rph_q;
  logic [15:0] rsh_q;
  logic [2:0]  rbn_q;
  logic [7:0]  rlen_q;
  wire [15:0] rsh_n = {rsh_q[14:0], dbit_q};
  assign rx_byte = rsh_n[7:0];
  always_comb begin
    push_rx    = 1'b0;
    rx_done_ev = 1'b0;
    if (bit_ok && rph_q == modem_pkg::RX_DATA && rbn_q == 3'h7) begin
      push_rx    = !rx_full;
      rx_done_ev = ph_en & (rlen_q == 8'h01);
    end
  end
  always_ff @(posedge clock) begin
    if (rst || !in_rx || rx_done_ev) begin
      rph_q  <= modem_pkg::RX_HUNT;
      rsh_q  <= 16'h0000;
      rbn_q  <= 3'h0;
      rlen_q <= 8'h00;
    end else if (bit_ok) begin
      rsh_q <= rsh_n;
      rbn_q <= rbn_q + 3'h1;
      case (rph_q)
        modem_pkg::RX_HUNT: begin
          rbn_q <= 3'h0;
          if (rsh_n == `SYNC_WORD)
            rph_q <= ph_en ? modem_pkg::RX_LEN : modem_pkg::RX_DATA;
        end
        modem_pkg::RX_LEN: begin
          if (rbn_q == 3'h7) begin
            rlen_q <= rx_byte;
            rph_q  <= (rx_byte == 8'h00) ? modem_pkg::RX_HUNT
                                         : modem_pkg::RX_DATA;
          end
        end
        modem_pkg::RX_DATA: begin
          if (rbn_q == 3'h7 && ph_en) rlen_q <= rlen_q - 8'h01;
        end
        default: rph_q <= modem_pkg::RX_HUNT;
      endcase
    end
  end

  // Sticky done flags; a new event beats the read that clears it
  logic tx_done_s, rx_done_s;
  wire  stat_rd = ev_cmd & (rb == `CMD_STAT);
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_done_s    <= 1'b0;
      rx_done_s    <= 1'b0;
      host_alert_n <= 1'b1;
    end else begin
      tx_done_s    <= tx_done_ev | (tx_done_s & !stat_rd);
      rx_done_s    <= rx_done_ev | (rx_done_s & !stat_rd);
      host_alert_n <= !(tx_done_s | rx_done_s);
    end
  end

  // Answer byte for the serial output
  wire [15:0] gaddr = {addr_q[15:8], rb};
  always_ff @(posedge clock) begin
    if (rst) begin
      out_byte_q <= 8'h00;
    end else if (stat_rd) begin
      out_byte_q <= {tx_done_s, rx_done_s, 1'b0, locked, 1'b0, state_q};
    end else if (cmd_q == `CMD_RRX && frame_on) begin
      out_byte_q <= rxm.rdata;
    end else if (byte_ev && bidx_q == 3'h2 && cmd_q == `CMD_GETP) begin
      out_byte_q <= (gaddr == `CFG_ADDR) ? cfg_q :
                    (gaddr == `CTL_ADDR) ? ctl_q : 8'h00;
    end
  end

  // Pins: direct clock out, live receive data and sample clock
  always_ff @(posedge clock) begin
    if (rst) begin
      gpio_o  <= 4'h0;
      gpio_oe <= 4'h0;
      sdo_oe  <= 1'b0;
    end else begin
      sdo_oe  <= frame_on;
      gpio_o  <= 4'h0;
      gpio_oe <= 4'h0;
      if (in_tx && src == `SRC_PIN && dsync) begin
        gpio_oe[dpin ^ 2'h1] <= 1'b1;
        gpio_o[dpin ^ 2'h1]  <= (tb_q < 6'(`BIT_CYC / 2));
      end
      if (in_rx && ctl_q[`C_RXOUT]) begin
        gpio_oe[3:2] <= 2'h3;
        gpio_o[2]    <= dbit_q;
        gpio_o[3]    <= (rb_q >= 6'(`BIT_CYC / 2));
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  cfg_reset_a: assert property (
    $fell(rst) |-> cfg_q == `CFG_RST)
    else $error("config not at reset value");
  rsv_write_a: assert property (
    set_ev && addr_q == `CFG_ADDR && rsv_wr |=> $stable(cfg_q))
    else $error("reserved config value taken");
  scheme_out_a: assert property (
    $changed(cfg_q) |-> ##1 mod_scheme == $past(cfg_q[2:0]))
    else $error("scheme output lags");
  tx_fill_a: assert property (
    push_tx |=> tx_cnt == $past(tx_cnt) + 1'b1 || $past(pop_tx))
    else $error("tx fifo write lost");
  rx_drain_a: assert property (
    pop_rx && !push_rx |=> rx_cnt == $past(rx_cnt) - 1'b1)
    else $error("rx fifo read lost");
  async_pass_a: assert property (
    in_tx && src == `SRC_PIN && !dsync ##1 in_tx && $stable(cfg_q)
      |-> mod_bit == $past(pin_d))
    else $error("async direct bit not passed");
  bit_lock_a: assert property (
    !async && edges_q < `LOCK_EDGES |-> !bit_ok)
    else $error("bit clock used before lock");
  alert_hold_a: assert property (
    tx_done_ev ##1 !stat_rd |-> ##1 !host_alert_n)
    else $error("alert not raised");
  done_exit_a: assert property (
    tx_done_ev && tx_next_q == 4'h0 && !ev_arg1 |=> !in_tx)
    else $error("tx not left on done");
  ph_off_a: assert property (
    bit_ok && !ph_en && rph_q == modem_pkg::RX_HUNT &&
      rsh_n == `SYNC_WORD |=> rph_q == modem_pkg::RX_DATA)
    else $error("data phase missed after sync");
endmodule // modem_data_path

// ===== modem_data_path_test.sv
// Purpose: Self-checking bench for the modem data path
// Assumes: Host model drives the link, bench drives pins and demod bit
// Notes:   Bit period 50 core clocks; outputs read at the rising edge
`timescale 1ns/100ps
`include "modem_defs.svh"
module modem_data_path_test;
  logic       clock;
  logic       rst;
  logic       sclk;
  logic       nsel;
  logic       sdi;
  logic [3:0] gpio_i;
  logic       rx_raw;
  logic       sdo_o;
  logic       sdo_oe;
  logic [3:0] gpio_o;
  logic [3:0] gpio_oe;
  logic       mod_bit;
  logic [2:0] mod_scheme;
  logic       mod_active;
  logic       host_alert_n;
  logic [7:0] tx_b [8];
  logic [7:0] rx_b [8];
  logic [7:0] b;
  logic [7:0] air [$];
  logic [7:0] txq [$];
  int         cfg_m;
  int         n;
  int         e;
  int         cyc;
  int         n_mismatch;
  int         checks_done;
  int         oe_miss;
  int         seed = 32'hDE3C9F02;

  modem_data_path modem_data_path_inst (
    .clock(clock), .rst(rst), .sclk(sclk), .nsel(nsel), .sdi(sdi),
    .gpio_i(gpio_i), .rx_raw(rx_raw), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .gpio_o(gpio_o), .gpio_oe(gpio_oe), .mod_bit(mod_bit),
    .mod_scheme(mod_scheme), .mod_active(mod_active),
    .host_alert_n(host_alert_n));

  modem_host modem_host_inst (
    .sclk(sclk), .nsel(nsel), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard well above the roughly 13.5k cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      results();
    end
  end

  // Output enable must already stand at every rising link clock edge
  always @(posedge sclk) begin
    if (sdo_oe !== 1'b1) oe_miss++;
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic send(input int k);
    modem_host_inst.frame(tx_b, k, rx_b);
    repeat (4) @(posedge clock);
  endtask

  task automatic cmd2(input logic [7:0] c, input logic [7:0] a);
    tx_b[0] = c;
    tx_b[1] = a;
    send(2);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    tx_b = '{`CMD_SETP, a[15:8], a[7:0], d, 8'h00, 8'h00, 8'h00, 8'h00};
    send(4);
  endtask

  // Answer lags two bytes, so the value rides in the fifth byte
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    tx_b = '{`CMD_GETP, a[15:8], a[7:0], 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    send(5);
    d = rx_b[4];
  endtask

  task automatic stat(output logic [7:0] s);
    tx_b[0] = `CMD_STAT;
    send(3);
    s = rx_b[2];
  endtask

  task automatic wait_act(input logic lvl, output int c);
    c = 0;
    while (mod_active !== lvl && c < 5000) begin
      @(posedge clock);
      c++;
    end
  endtask

  initial begin
    rst = 1'b1;
    gpio_i = 4'h0;
    rx_raw = 1'b0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
    chk_sig(16'(mod_scheme), 16'h0002);
    chk_sig(16'(host_alert_n), 16'h0001);
    cfg_m = 2;
    rd(`CFG_ADDR, b);
    chk_byte(b, 8'h02);
    for (int s = 0; s < 9; s++) begin
      b = (s == 8) ? 8'h1A : (8'($random(seed)) & 8'hE0) | 8'(s);
      if (b[2:0] < 3'h6 && b[4:3] != 2'h3) cfg_m = b;
      wr(`CFG_ADDR, b);
      rd(`CFG_ADDR, b);
      chk_byte(b, 8'(cfg_m));
      chk_sig(16'(mod_scheme), 16'(cfg_m[2:0]));
    end
    $display("test config done");

    for (int p = 0; p < 4; p++) begin
      // Gaussian codes ask for async timing; sync must win
      b = {1'b1, 2'(p), `SRC_PIN,
           p[0] ? (p[1] ? `SCH_4GFSK : `SCH_2GFSK) : 3'h2};
      wr(`CFG_ADDR, b);
      // Next state TX keeps the modulator up for the whole pass
      cmd2(`CMD_TX, {4'h0, `NS_TX});
      for (int k = 0; k < 3; k++) begin
        gpio_i <= 4'($random(seed));
        repeat (120) @(posedge clock);
        chk_sig(16'(mod_bit), 16'(gpio_i[p]));
      end
      if (p[0]) chk_sig(16'(gpio_oe[p ^ 1]), 16'h0001);
      else chk_sig(16'(gpio_oe), 16'h0000);
      cmd2(`CMD_CHG, 8'h00);
    end
    stat(b);
    $display("test direct done");

    wr(`CFG_ADDR, 8'h02);
    for (int ph = 0; ph < 2; ph++) begin
      wr(`CTL_ADDR, 8'(ph));
      tx_b[0] = `CMD_WTX;
      for (int i = 1; i < 4; i++) begin
        tx_b[i] = 8'($random(seed));
        txq.push_back(tx_b[i]);
      end
      send(4);
      if (ph == 1) begin
        txq.push_front(8'hD4);
        txq.push_front(8'h2D);
        repeat (4) txq.push_front(`PRE_PAT);
      end
      fork
        cmd2(`CMD_TX, 8'h00);
        begin
          wait_act(1'b1, n);
          // First bit starts one bit period in; look mid-bit
          repeat (24) @(posedge clock);
          for (int i = 0; i < txq.size(); i++) begin
            for (int k = 7; k >= 0; k--) begin
              repeat (50) @(posedge clock);
              chk_sig(16'(mod_bit), 16'(txq[i][k]));
            end
          end
          wait_act(1'b0, n);
        end
      join
      n = n + 24 + txq.size() * 8 * 50;
      e = (txq.size() * 8 + 1) * 50;
      chk_sig(16'(n), 16'(e));
      txq.delete();
      repeat (5) @(posedge clock);
      chk_sig(16'(host_alert_n), 16'h0000);
      stat(b);
      chk_sig(16'({b[7], b[2:0]}), 16'({1'b1, modem_pkg::ST_IDLE}));
      repeat (5) @(posedge clock);
      chk_sig(16'(host_alert_n), 16'h0001);
    end
    $display("test fifo tx done");

    wr(`CTL_ADDR, 8'h07);
    cmd2(`CMD_RX, 8'h00);
    air = '{8'h0F, 8'h0F, 8'h2D, 8'hD4, 8'h02, 8'($random(seed)),
            8'($random(seed))};
    for (int i = 0; i < 7; i++) begin
      for (int k = 7; k >= 0; k--) begin
        rx_raw <= air[i][k];
        // Look before the last strobe, which ends receive
        repeat (20) @(posedge clock);
        chk_sig(16'({gpio_oe[3:2], gpio_o[2]}), 16'({2'h3, air[i][k]}));
        // Sample clock low early in a bit once edges have aligned it
        if (i > 0) chk_sig(16'(gpio_o[3]), 16'h0000);
        repeat (30) @(posedge clock);
      end
    end
    repeat (10) @(posedge clock);
    chk_sig(16'(host_alert_n), 16'h0000);
    tx_b[0] = `CMD_RRX;
    send(4);
    chk_byte(rx_b[2], air[5]);
    chk_byte(rx_b[3], air[6]);
    stat(b);
    chk_sig(16'(b[6]), 16'h0001);
    chk_sig(16'(oe_miss), 16'h0000);
    $display("test fifo rx done");
    results();
  end
endmodule // modem_data_path_test

// ===== modem_defs.svh
// Purpose: Constants for the modem data path block
// Assumes: 50 MHz core clock, byte-wide command link
// Notes:   Definitions only
`ifndef MODEM_DEFS_SVH
`define MODEM_DEFS_SVH
`define CFG_ADDR   16'h2000
`define CFG_RST    8'h02
`define CTL_ADDR   16'h2001
`define CTL_RST    8'h00
`define F_SCHEME   2:0
`define F_SOURCE   4:3
`define F_PIN      6:5
`define F_TIMING   7
`define C_PH_EN    0
`define C_ASYNC    1
`define C_RXOUT    2
`define SCH_MAX    3'h5
`define SCH_2GFSK  3'h3
`define SCH_4GFSK  3'h5
`define SRC_FIFO   2'h0
`define SRC_PIN    2'h1
`define SRC_PRBS   2'h2
`define SRC_RSV    2'h3
`define CMD_SETP   8'h11
`define CMD_GETP   8'h12
`define CMD_STAT   8'h20
`define CMD_TX     8'h31
`define CMD_RX     8'h32
`define CMD_CHG    8'h34
`define CMD_WTX    8'h66
`define CMD_RRX    8'h77
`define NS_TX      4'h7
`define NS_RX      4'h8
`define TBIT_NS    1000
`define CLK_NS     20
`define BIT_CYC    ((`TBIT_NS + `CLK_NS - 1) / `CLK_NS)
`define LOCK_EDGES 3'h4
`define PRE_BYTES  3'h4
`define SEG_PAY    3'h6
`define PRE_PAT    8'hAA
`define SYNC_WORD  16'h2DD4
`define PRBS_SEED  9'h1FF
`define AW         6
`define BIDX_MAX   3'h7
`endif

// ===== modem_host.sv
// Purpose: Host side of the command link, byte frames in mode 0
// Assumes: 32 ns link clock that runs only inside frames
// Notes:   Released data line toggles so a stale bit never looks valid
`timescale 1ns/100ps
module modem_host (
  output logic      sclk,
  output logic      nsel,
  output logic      sdi,
  input  wire logic sdo_o,
  input  wire logic sdo_oe
);
  initial begin
    sclk = 1'b0;
    nsel = 1'b1;
    sdi  = 1'b0;
  end

  always #16 if (nsel) sdi = ~sdi;

  // MSB first, answer sampled on the rising edge
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      sdi = d[i];
      #16 sclk = 1'b1;
      q[i] = sdo_o;
      #16 sclk = 1'b0;
    end
    // Spacing above eight core clocks between bytes
    #200;
  endtask

  task automatic frame(input logic [7:0] tx [8], input int n,
                       output logic [7:0] rx [8]);
    nsel = 1'b0;
    #100;
    for (int k = 0; k < n; k++) xfer(tx[k], rx[k]);
    nsel = 1'b1;
    #100;
  endtask
endmodule // modem_host

// ===== modem_pkg.sv
// Purpose: Types shared by the modem data path
// Assumes: modem_defs.svh for numbers
// Notes:   One-hot state codes
package modem_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TX   = 3'b010,
    ST_RX   = 3'b100
  } radio_state_e;
  typedef enum logic [2:0] {
    RX_HUNT = 3'b001,
    RX_LEN  = 3'b010,
    RX_DATA = 3'b100
  } rx_phase_e;
endpackage
